/* File: dv/jesd_link_param_power_config_bench.sv */
`timescale 1ns/1ps
module jesd_link_param_power_config_bench;
  import jlp_pkg::*;
  logic       clock, reset_n, power_down_pin, reg_write, reg_read, reg_rvalid, ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lane_checksum, mfc_offset, pvec, rv, pm;
  logic [7:0] sub_p, drv_p, mfc_p, pre_p, sub_a, drv_a, mfc_a, pre_a;
  logic [4:0] sample_bits_m1;
  logic [1:0] link_subclass;
  logic       preemphasis_on, driver_power_down, settings_transfer, core_power_down, core_standby;
  logic       link_pll_on, serializer_on, link_clocks_on, link_logic_reset, link_standby;
  int         err_total = 0, compares = 0, seed = 25, cycles = 0;
  localparam logic [7:0] RA [11] = '{8'h08, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h80, 8'h8B, 8'hA8, 8'hFF, 8'h10};
  localparam logic [7:0] RE [11] = '{8'h00, 8'h2F, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00};
  localparam logic [7:0] WA [6] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'h79, 8'h10};
  assign pvec = {driver_power_down, core_power_down, core_standby, link_pll_on, serializer_on,
                 link_clocks_on, link_logic_reset, link_standby};
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  jlp_link_param_power_config i_jlp_link_param_power_config (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .lane_checksum(lane_checksum), .power_down_pin(power_down_pin), .link_subclass(link_subclass),
    .sample_bits_m1(sample_bits_m1), .mfc_offset(mfc_offset), .preemphasis_on(preemphasis_on),
    .driver_power_down(driver_power_down), .settings_transfer(settings_transfer),
    .core_power_down(core_power_down), .core_standby(core_standby), .link_pll_on(link_pll_on),
    .serializer_on(serializer_on), .link_clocks_on(link_clocks_on),
    .link_logic_reset(link_logic_reset), .link_standby(link_standby));
  jlp_host_model i_jlp_host_model (
    .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic results();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_jlp_host_model.rd(a, rv, ok);
    check({7'h00, ok}, 8'h01);
    check(rv, exp);
  endtask
  // full power-down beats standby; standby leaves the pll running
  function automatic logic [7:0] pwr_exp(input logic [7:0] m, input logic pin, input logic drv);
    logic fpd, ps, cpd, lpd, lst;
    fpd = pin & ~m[5];
    ps  = pin & m[5];
    cpd = fpd | (m[1:0] == 2'h1);
    lpd = fpd | (m[3:2] == 2'h1);
    lst = ~lpd & ((ps & m[4]) | (m[3:2] == 2'h2));
    return {drv | lpd | lst, cpd, ~cpd & (ps | (m[1:0] == 2'h2)), ~lpd, ~(lpd | lst), ~(lpd | lst), lpd | lst, lst};
  endfunction
  task automatic out_chk();
    check({6'h00, link_subclass}, {6'h00, sub_a[6:5]});
    check({3'h0, sample_bits_m1}, {3'h0, sub_a[4:0]});
    check(mfc_offset, mfc_a);
    check({7'h00, preemphasis_on}, {7'h00, pre_a == 8'h14});
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total = err_total + 1;
      results();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    power_down_pin = 1'b0;
    lane_checksum = 8'h00;
    {sub_a, drv_a, mfc_a, pre_a} = {8'h2F, 8'h00, 8'h00, 8'h04};
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    check(pvec, pwr_exp(8'h00, 1'b0, 1'b0));
    out_chk();
    for (int p = 0; p < 2; p++) begin
      @(posedge clock);
      lane_checksum <= 8'($random(seed));
      foreach (RA[i]) rd_chk(RA[i], RE[i]);
      rd_chk(8'h79, lane_checksum);
      if (p == 0) foreach (WA[i]) i_jlp_host_model.wr(WA[i], 8'($random(seed)));
    end
    $display("test reset and read-only done");
    for (int i = 0; i < 6; i++) begin
      sub_p = 8'($random(seed));
      sub_p[6:5] = {1'b0, i[0]};
      if (i == 0) sub_p[4:0] = 5'h0F;
      {drv_p, mfc_p, pre_p} = {8'($random(seed)), 8'($random(seed)), i[1] ? 8'h14 : 8'h04};
      i_jlp_host_model.wr(8'h73, sub_p);
      i_jlp_host_model.wr(8'h80, drv_p);
      i_jlp_host_model.wr(8'h8B, mfc_p);
      i_jlp_host_model.preemph(i[1]);
      rd_chk(8'h73, sub_p & 8'h7F);
      rd_chk(8'h80, drv_p & 8'h01);
      rd_chk(8'h8B, mfc_p);
      rd_chk(8'hA8, pre_p);
      out_chk();
      check(pvec, pwr_exp(8'h00, 1'b0, drv_a[0]));
      i_jlp_host_model.update();
      #1;
      check({7'h00, settings_transfer}, 8'h01);
      @(posedge clock);
      #1;
      {sub_a, drv_a, mfc_a, pre_a} = {sub_p & 8'h7F, drv_p & 8'h01, mfc_p, pre_p};
      check({7'h00, settings_transfer}, 8'h00);
      // outputs are registered from active, one edge after it loads
      @(posedge clock);
      #1;
      out_chk();
      check(pvec, pwr_exp(8'h00, 1'b0, drv_a[0]));
      rd_chk(8'hFF, 8'h00);
    end
    $display("test shadow transfer done");
    repeat (3) @(posedge clock);
    power_down_pin <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check(pvec, pwr_exp(8'h00, 1'b0, drv_a[0]));
    repeat (3) @(posedge clock);
    #1;
    check(pvec, pwr_exp(8'h00, 1'b1, drv_a[0]));
    for (int k = 0; k < 72; k++) begin
      pm = {2'($random(seed)), k[0], k[1], 2'((k / 4) % 3), 2'((k / 12) % 3)};
      @(posedge clock);
      power_down_pin <= (k >= 36);
      i_jlp_host_model.wr(8'h08, pm);
      repeat (8) @(posedge clock);
      #1;
      check(pvec, pwr_exp(pm, k >= 36, drv_a[0]));
      check({core_power_down, core_standby}, (pwr_exp(pm, k >= 36, 1'b0) >> 5) & 8'h03);
      rd_chk(8'h08, pm & 8'h3F);
    end
    $display("test power modes done");
    results();
  end
endmodule

/* File: dv/jlp_config_assertions.sv */
`timescale 1ns/1ps
module jlp_config_assertions (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [7:0] lane_checksum,
  input wire logic [1:0] link_subclass,
  input wire logic [4:0] sample_bits_m1,
  input wire logic [7:0] mfc_offset,
  input wire logic       preemphasis_on,
  input wire logic       driver_power_down,
  input wire logic       settings_transfer,
  input wire logic       core_power_down,
  input wire logic       core_standby,
  input wire logic       link_pll_on,
  input wire logic       serializer_on,
  input wire logic       link_clocks_on,
  input wire logic       link_logic_reset,
  input wire logic       link_standby
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic wr08;
  assign wr08 = reg_write && reg_addr == 8'h08;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_checksum_read: assert property (reg_read && reg_addr == 8'h79 |=>
    reg_rvalid && reg_rdata == $past(lane_checksum)) else $error("checksum read wrong");
  chk_density_zero: assert property (reg_read && reg_addr == 8'h75 |=> reg_rdata == 8'h00)
    else $error("density register not zero");
  chk_spf_fixed: assert property (reg_read && reg_addr == 8'h74 |=> reg_rdata[4:0] == 5'h00)
    else $error("samples per frame not fixed");
  chk_transfer_pulse: assert property (reg_write && reg_addr == 8'hFF && reg_wdata[0] |=>
    settings_transfer ##1 !settings_transfer) else $error("transfer pulse wrong");
  chk_active_on_transfer: assert property ($changed({link_subclass, sample_bits_m1, mfc_offset,
    preemphasis_on}) |-> $past(settings_transfer, 2)) else $error("active value moved without transfer");
  chk_link_mode_off: assert property (wr08 && reg_wdata[3:2] == 2'h1 |=> ##1
    !link_pll_on && !serializer_on && !link_clocks_on && link_logic_reset) else $error("link off wrong");
  chk_link_mode_stby: assert property (wr08 && reg_wdata[3:2] == 2'h2 && reg_wdata[5] |=> ##1
    link_pll_on && !serializer_on && !link_clocks_on && link_logic_reset) else $error("link stby wrong");
  chk_core_mode_off: assert property (wr08 && reg_wdata[1:0] == 2'h1 |=> ##1
    core_power_down && !core_standby) else $error("core off wrong");
  chk_core_mode_stby: assert property (wr08 && reg_wdata[1:0] == 2'h2 && reg_wdata[5] |=> ##1
    core_standby && !core_power_down) else $error("core stby wrong");
  chk_link_state_tie: assert property (link_logic_reset == !serializer_on &&
    serializer_on == link_clocks_on) else $error("link state mixed");
  chk_driver_forced: assert property (link_logic_reset |-> driver_power_down)
    else $error("driver on with link down");
  chk_core_exclusive: assert property (!(core_power_down && core_standby))
    else $error("core in two states");
  cov_transfer: cover property (settings_transfer);
  cov_link_stby: cover property (link_standby && link_pll_on);
  cov_core_stby: cover property (core_standby && !link_standby);
  cov_read: cover property (reg_rvalid);
endmodule
bind jlp_link_param_power_config jlp_config_assertions i_jlp_config_assertions (.*);

/* File: dv/jlp_host_model.sv */
`timescale 1ns/1ps
module jlp_host_model (
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  output logic            reg_read,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // idle lines show the inverse, so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h74) v[5] = 1'b1;
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1;
    d  = reg_rdata;
    ok = reg_rvalid;
  endtask
  task automatic preemph(input logic on);
    wr(8'hA8, on ? 8'h14 : 8'h04);
  endtask
  task automatic update();
    wr(8'hFF, 8'h01);
  endtask
endmodule

/* File: logic/jlp_link_param_power_config.sv */
// Summary of operation
// - N' stored minus one, so 0xF means sixteen bits per sample
// - samples-per-frame field is read only, minus-one form, writes ignored
// - density flag and control-word count read only, register resets to zero
// - register holds the configuration checksum of the single output lane
// - driver control bit 0: zero enables output driver unless the link is powered down or in standby, one powers it down
// - preemphasis register 0x04 turns preemphasis off, 0x14 on; off by default
// - pin mode bit zero: asserted power-down pin gives full power-down
// - pin mode bit one: asserted power-down pin gives standby
// - link standby bit zero keeps link logic out of pin standby
// - link standby bit one: link standby only with pin asserted and mode one
// - link power field 00 runs link logic normally
// - link field 01: pll, serializer, clocks off, link logic in reset
// - link field 10: pll on, serializer and clocks off, logic in reset
// - converter power field acts on converter core only
// - converter field 00 runs the core normally
// - converter field 01 powers the core down
// - converter field 10 puts the core in standby
`timescale 1ns/1ps
module jlp_link_param_power_config
  import jlp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic [7:0] lane_checksum,
  input  wire logic       power_down_pin,
  output logic      [1:0] link_subclass,
  output logic      [4:0] sample_bits_m1,
  output logic      [7:0] mfc_offset,
  output logic            preemphasis_on,
  output logic            driver_power_down,
  output logic            settings_transfer,
  output logic            core_power_down,
  output logic            core_standby,
  output logic            link_pll_on,
  output logic            serializer_on,
  output logic            link_clocks_on,
  output logic            link_logic_reset,
  output logic            link_standby
);
  import jlp_pkg::*;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic wr_pdm;
  logic wr_subclass;
  logic wr_spf;
  logic wr_driver;
  logic wr_mfc;
  logic wr_preemph;
  logic wr_update;

  assign wr_pdm      = reg_write && (reg_addr == ADDR_POWER_DOWN_MODES);
  assign wr_subclass = reg_write && (reg_addr == ADDR_SUBCLASS_SAMPLE);
  assign wr_spf      = reg_write && (reg_addr == ADDR_SAMPLES_PER_FRAME);
  assign wr_driver   = reg_write && (reg_addr == ADDR_DRIVER_CONTROL);
  assign wr_mfc      = reg_write && (reg_addr == ADDR_MFC_OFFSET);
  assign wr_preemph  = reg_write && (reg_addr == ADDR_PREEMPHASIS);
  assign wr_update   = reg_write && (reg_addr == ADDR_GLOBAL_UPDATE);

  // ---------------------------------------------------------------
  // global update strobe
  // ---------------------------------------------------------------
  logic update_reg;
  logic update_next;

  // self clearing: one cycle high after a write of one
  always_comb begin
    update_next = wr_update && reg_wdata[TRANSFER_BIT];
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      update_reg <= RST_GLOBAL_UPDATE[TRANSFER_BIT];
    end else begin
      update_reg <= update_next;
    end
  end

  assign settings_transfer = update_reg;

  // ---------------------------------------------------------------
  // shadowed link registers
  // ---------------------------------------------------------------
  logic [7:0] subclass_pending;
  logic [7:0] subclass_active;
  logic [7:0] driver_pending;
  logic [7:0] driver_active;
  logic [7:0] mfc_pending;
  logic [7:0] mfc_active;
  logic [7:0] preemph_pending;
  logic [7:0] preemph_active;
  logic [7:0] driver_wdata;
  logic [7:0] subclass_wdata;

  // only the defined fields are stored; the rest reads zero
  assign subclass_wdata = {1'b0, reg_wdata[SUBCLASS_HI:SUBCLASS_LO], reg_wdata[NPRIME_HI:NPRIME_LO]};
  assign driver_wdata   = {7'h00, reg_wdata[DRIVER_PD_BIT]};

  jlp_shadow_reg #(
    .WIDTH (8),
    .RESET (RST_SUBCLASS_SAMPLE)
  ) u_subclass (
    .clock      (clock),
    .reset_n    (reset_n),
    .write_en   (wr_subclass),
    .write_data (subclass_wdata),
    .transfer   (update_reg),
    .pending    (subclass_pending),
    .active     (subclass_active)
  );

  jlp_shadow_reg #(
    .WIDTH (8),
    .RESET (RST_DRIVER_CONTROL)
  ) u_driver (
    .clock      (clock),
    .reset_n    (reset_n),
    .write_en   (wr_driver),
    .write_data (driver_wdata),
    .transfer   (update_reg),
    .pending    (driver_pending),
    .active     (driver_active)
  );

  jlp_shadow_reg #(
    .WIDTH (8),
    .RESET (RST_MFC_OFFSET)
  ) u_mfc (
    .clock      (clock),
    .reset_n    (reset_n),
    .write_en   (wr_mfc),
    .write_data (reg_wdata),
    .transfer   (update_reg),
    .pending    (mfc_pending),
    .active     (mfc_active)
  );

  jlp_shadow_reg #(
    .WIDTH (8),
    .RESET (RST_PREEMPHASIS)
  ) u_preemph (
    .clock      (clock),
    .reset_n    (reset_n),
    .write_en   (wr_preemph),
    .write_data (reg_wdata),
    .transfer   (update_reg),
    .pending    (preemph_pending),
    .active     (preemph_active)
  );

  // ---------------------------------------------------------------
  // link parameter outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      link_subclass  <= RST_SUBCLASS_SAMPLE[SUBCLASS_HI:SUBCLASS_LO];
      sample_bits_m1 <= RST_SUBCLASS_SAMPLE[NPRIME_HI:NPRIME_LO];
    end else begin
      link_subclass  <= subclass_active[SUBCLASS_HI:SUBCLASS_LO];
      sample_bits_m1 <= subclass_active[NPRIME_HI:NPRIME_LO];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mfc_offset <= RST_MFC_OFFSET;
    end else begin
      mfc_offset <= mfc_active;
    end
  end

  // codes other than the on code are taken as off, the safe case
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      preemphasis_on <= 1'b0;
    end else begin
      preemphasis_on <= (preemph_active == PREEMPH_ON_CODE);
    end
  end

  // ---------------------------------------------------------------
  // samples-per-frame reserved bit
  // ---------------------------------------------------------------
  logic spf_reserved_reg;

  // stored as written; the host is expected to write one here
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      spf_reserved_reg <= RST_SAMPLES_PER_FRAME[SPF_RESERVED_BIT];
    end else if (wr_spf) begin
      spf_reserved_reg <= reg_wdata[SPF_RESERVED_BIT];
    end
  end

  // ---------------------------------------------------------------
  // power-down modes register (acts at once, not shadowed)
  // ---------------------------------------------------------------
  logic [7:0] pdm_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pdm_reg <= RST_POWER_DOWN_MODES;
    end else if (wr_pdm) begin
      pdm_reg <= reg_wdata & PDM_WRITE_MASK;
    end
  end

  // ---------------------------------------------------------------
  // power-down pin synchroniser
  // ---------------------------------------------------------------
  logic [PIN_SYNC_STAGES-1:0] pin_sync_reg;
  logic                       pin_level_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync_reg <= '0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[PIN_SYNC_STAGES-2:0], power_down_pin};
    end
  end

  // change accepted only when stages two and three agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_level_reg <= 1'b0;
    end else if (pin_sync_reg[1] == pin_sync_reg[2]) begin
      pin_level_reg <= pin_sync_reg[2];
    end
  end

  // ---------------------------------------------------------------
  // power state decode
  // ---------------------------------------------------------------
  logic       ext_pin_mode;
  logic       link_stby_enable;
  logic [1:0] link_mode;
  logic [1:0] core_mode;
  logic       pin_full_pd;
  logic       pin_standby;
  logic       pin_link_stby;
  logic       core_pd_next;
  logic       core_stby_next;
  logic       link_pd_next;
  logic       link_stby_next;

  assign ext_pin_mode     = pdm_reg[PDM_EXT_PIN_MODE_BIT];
  assign link_stby_enable = pdm_reg[PDM_LINK_STANDBY_BIT];
  assign link_mode        = pdm_reg[PDM_LINK_MODE_HI:PDM_LINK_MODE_LO];
  assign core_mode        = pdm_reg[PDM_CORE_MODE_HI:PDM_CORE_MODE_LO];

  always_comb begin
    pin_full_pd    = pin_level_reg && !ext_pin_mode;
    pin_standby    = pin_level_reg && ext_pin_mode;
    // link joins pin standby only when enabled
    pin_link_stby  = pin_standby && link_stby_enable;
    // core field touches only the converter core
    core_pd_next   = pin_full_pd || (core_mode == PMODE_POWER_DOWN);
    core_stby_next = !core_pd_next && (pin_standby || (core_mode == PMODE_STANDBY));
    link_pd_next   = pin_full_pd || (link_mode == PMODE_POWER_DOWN);
    link_stby_next = !link_pd_next && (pin_link_stby || (link_mode == PMODE_STANDBY));
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      core_power_down <= 1'b0;
      core_standby    <= 1'b0;
    end else begin
      core_power_down <= core_pd_next;
      core_standby    <= core_stby_next;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      link_pll_on      <= 1'b1;
      serializer_on    <= 1'b1;
      link_clocks_on   <= 1'b1;
      link_logic_reset <= 1'b0;
      link_standby     <= 1'b0;
    end else begin
      link_pll_on      <= !link_pd_next;
      serializer_on    <= !(link_pd_next || link_stby_next);
      link_clocks_on   <= !(link_pd_next || link_stby_next);
      link_logic_reset <= link_pd_next || link_stby_next;
      link_standby     <= link_stby_next;
    end
  end

  // driver is also off whenever the serializer is off
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      driver_power_down <= RST_DRIVER_CONTROL[DRIVER_PD_BIT];
    end else begin
      driver_power_down <= driver_active[DRIVER_PD_BIT] || link_pd_next || link_stby_next;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = READ_ZERO;
    unique case (reg_addr)
      ADDR_POWER_DOWN_MODES:   rdata_next = pdm_reg;
      ADDR_SUBCLASS_SAMPLE:    rdata_next = subclass_pending;
      // value field is a constant, so writes cannot reach it
      ADDR_SAMPLES_PER_FRAME:  rdata_next = {2'h0, spf_reserved_reg, SAMPLES_PER_FRAME_M1};
      ADDR_DENSITY_CTRL_WORDS: rdata_next = {HD_VALUE, 2'h0, CF_VALUE};
      ADDR_RESERVED_ONE:       rdata_next = READ_ZERO;
      ADDR_RESERVED_TWO:       rdata_next = READ_ZERO;
      ADDR_LANE_CHECKSUM:      rdata_next = lane_checksum;
      ADDR_DRIVER_CONTROL:     rdata_next = driver_pending;
      ADDR_MFC_OFFSET:         rdata_next = mfc_pending;
      ADDR_PREEMPHASIS:        rdata_next = preemph_pending;
      ADDR_GLOBAL_UPDATE:      rdata_next = {7'h00, update_reg};
      default:                 rdata_next = READ_ZERO;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_read) begin
      reg_rdata <= rdata_next;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
    end
  end

endmodule

/* File: logic/jlp_pkg.sv */
package jlp_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_DOWN_MODES   = 8'h08;
  localparam logic [7:0] ADDR_SUBCLASS_SAMPLE    = 8'h73;
  localparam logic [7:0] ADDR_SAMPLES_PER_FRAME  = 8'h74;
  localparam logic [7:0] ADDR_DENSITY_CTRL_WORDS = 8'h75;
  localparam logic [7:0] ADDR_RESERVED_ONE       = 8'h76;
  localparam logic [7:0] ADDR_RESERVED_TWO       = 8'h77;
  localparam logic [7:0] ADDR_LANE_CHECKSUM      = 8'h79;
  localparam logic [7:0] ADDR_DRIVER_CONTROL     = 8'h80;
  localparam logic [7:0] ADDR_MFC_OFFSET         = 8'h8B;
  localparam logic [7:0] ADDR_PREEMPHASIS        = 8'hA8;
  localparam logic [7:0] ADDR_GLOBAL_UPDATE      = 8'hFF;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_POWER_DOWN_MODES   = 8'h00;
  localparam logic [7:0] RST_SUBCLASS_SAMPLE    = 8'h2F;
  localparam logic [7:0] RST_SAMPLES_PER_FRAME  = 8'h20;
  localparam logic [7:0] RST_DENSITY_CTRL_WORDS = 8'h00;
  localparam logic [7:0] RST_DRIVER_CONTROL     = 8'h00;
  localparam logic [7:0] RST_MFC_OFFSET         = 8'h00;
  localparam logic [7:0] RST_PREEMPHASIS        = 8'h04;
  localparam logic [7:0] RST_GLOBAL_UPDATE      = 8'h00;
  localparam logic [7:0] READ_ZERO              = 8'h00;

  // ---------------------------------------------------------------
  // field layouts
  // ---------------------------------------------------------------
  localparam int PDM_EXT_PIN_MODE_BIT  = 5;
  localparam int PDM_LINK_STANDBY_BIT  = 4;
  localparam int PDM_LINK_MODE_HI      = 3;
  localparam int PDM_LINK_MODE_LO      = 2;
  localparam int PDM_CORE_MODE_HI      = 1;
  localparam int PDM_CORE_MODE_LO      = 0;
  localparam logic [7:0] PDM_WRITE_MASK = 8'h3F;

  localparam int SUBCLASS_HI           = 6;
  localparam int SUBCLASS_LO           = 5;
  localparam int NPRIME_HI             = 4;
  localparam int NPRIME_LO             = 0;

  localparam int SPF_RESERVED_BIT      = 5;
  localparam int SPF_VALUE_HI          = 4;
  localparam int SPF_VALUE_LO          = 0;
  localparam logic [4:0] SAMPLES_PER_FRAME_M1 = 5'h00;

  localparam int HD_BIT                = 7;
  localparam int CF_HI                 = 4;
  localparam int CF_LO                 = 0;
  localparam logic       HD_VALUE      = 1'b0;
  localparam logic [4:0] CF_VALUE      = 5'h00;

  localparam int DRIVER_PD_BIT         = 0;
  localparam int TRANSFER_BIT          = 0;

  localparam logic [7:0] PREEMPH_OFF_CODE = 8'h04;
  localparam logic [7:0] PREEMPH_ON_CODE  = 8'h14;

  // ---------------------------------------------------------------
  // power mode codes
  // ---------------------------------------------------------------
  localparam logic [1:0] PMODE_NORMAL     = 2'h0;
  localparam logic [1:0] PMODE_POWER_DOWN = 2'h1;
  localparam logic [1:0] PMODE_STANDBY    = 2'h2;

  localparam logic [1:0] SUBCLASS_0 = 2'h0;
  localparam logic [1:0] SUBCLASS_1 = 2'h1;

  localparam int PIN_SYNC_STAGES = 3;

endpackage

/* File: logic/jlp_shadow_reg.sv */
`timescale 1ns/1ps
module jlp_shadow_reg #(
  parameter int         WIDTH = 8,
  parameter logic [7:0] RESET = 8'h00
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             write_en,
  input  wire logic [WIDTH-1:0] write_data,
  input  wire logic             transfer,
  output logic      [WIDTH-1:0] pending,
  output logic      [WIDTH-1:0] active
);

  // ---------------------------------------------------------------
  // pending copy, written by the host
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pending <= RESET[WIDTH-1:0];
    end else if (write_en) begin
      pending <= write_data;
    end
  end

  // ---------------------------------------------------------------
  // active copy, loaded only on transfer
  // ---------------------------------------------------------------
  // a write in the transfer cycle waits for the next transfer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      active <= RESET[WIDTH-1:0];
    end else if (transfer) begin
      active <= pending;
    end
  end

endmodule
